/* File: design/rsm_mode_ctrl.sv */
/*
  Run/stop operating mode controller: mode selection, last sweeps, halt and
  fault stop, switch protection, stop-to-run init, power-up restore and flash
  copy abort handling.
  Assumes sweep engine, fault table and flash mover are outside; they are
  driven by the one-cycle strobes of this module and report back by pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsm_params.svh"

module rsm_mode_ctrl
  import rsm_pkg::*;
#(
  parameter int BG_LIMIT_CYC = `RSM_BG_LIMIT_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Mode switch pins (asynchronous)
  input wire logic [1:0] i_switch_pos,
  // Configuration
  input wire logic i_switch_en,
  input wire logic i_protect_en,
  input wire logic i_stop_io_scan_cfg,
  input wire logic i_redundant,
  input wire logic [7:0] i_last_sweeps,
  input wire logic [1:0] i_logic_src,
  input wire logic [1:0] i_ref_src,
  // Mode requests from tool, logic blocks, C calls
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_mode,
  input wire logic i_req_privileged,
  input wire logic i_stop_after_sweeps_request,
  input wire logic [7:0] i_stop_after_count,
  // Sweep and faults
  input wire logic i_sweep_done,
  input wire logic i_fault_event,
  input wire logic i_fault_fatal,
  input wire logic i_fault_table_clear,
  input wire logic i_wdog_expired,
  input wire logic i_ecc_error,
  // Power-up and flash
  input wire logic i_powerup,
  input wire logic i_backup_present,
  input wire logic i_user_mem_ok,
  input wire logic i_flash_write_start,
  input wire logic i_flash_read_start,
  input wire logic i_flash_done,
  input wire logic i_flash_abort,
  input wire logic i_init_done,
  // Status
  output logic [2:0] o_mode,
  output logic o_exec_logic,
  output logic o_scan_inputs,
  output logic o_drive_outputs,
  output logic o_outputs_default,
  output logic o_comms_to_completion,
  output logic o_bg_limit_active,
  output logic o_client_comms_en,
  output logic o_server_frozen,
  output logic o_backplane_en,
  output logic o_mem_write_protect,
  output logic [1:0] o_switch_pos,
  output logic [2:0] o_switch_cfg_mode,
  output logic o_diag_flag,
  output logic o_fault_log,
  output logic o_init_pulse,
  output logic o_restore_logic,
  output logic o_restore_ref,
  output logic o_restore_oem_pw,
  output logic o_flash_write_all,
  output logic o_flash_erase,
  output logic o_user_mem_clear,
  output logic o_bg_expired
);

  // ============================================================
  // State
  localparam logic [1:0] SRC_FLASH_ALWAYS = 2'h2;
  localparam logic [1:0] SRC_FLASH_COND = 2'h1;
  localparam int BGW = $clog2(BG_LIMIT_CYC + 1);

  typedef struct packed {
    logic [1:0] sw_m;
    logic [1:0] sw;
    logic [1:0] sw_old;
    rsm_mode_e mode;
    rsm_mode_e target;
    logic stopping;
    logic [7:0] last_cnt;
    logic backplane;
    logic halt_hold;
    logic init_pending;
    rsm_fl_e fl;
    logic [BGW-1:0] bg_cnt;
    logic bg_expired;
    logic diag;
    logic log_p;
    logic init_p;
    logic rl;
    logic rr;
    logic roem;
    logic fw;
    logic fe;
    logic umc;
  } rsm_state_s;

  rsm_state_s s_q;
  rsm_state_s s_d;
  logic run_mode;
  logic stop_mode;
  logic sw_blocks_run;
  rsm_mode_e stop_target;

  // Decoded mode classes
  always_comb begin
    run_mode = (s_q.mode == RSM_RUN_OUT_EN) || (s_q.mode == RSM_RUN_OUT_DIS);
    stop_mode = (s_q.mode == RSM_STOP_IO_EN) || (s_q.mode == RSM_STOP_IO_DIS);
    sw_blocks_run = i_switch_en && (s_q.sw == RSM_SW_STOP);
    // Redundant parts never scan in stop, whatever the configuration
    stop_target = (i_stop_io_scan_cfg && !i_redundant) ? RSM_STOP_IO_EN : RSM_STOP_IO_DIS;
  end

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sw_m = i_switch_pos;
    s_d.sw = s_q.sw_m;
    s_d.sw_old = s_q.sw;
    s_d.log_p = 1'b0;
    s_d.init_p = 1'b0;
    s_d.rl = 1'b0;
    s_d.rr = 1'b0;
    s_d.roem = 1'b0;
    s_d.fw = 1'b0;
    s_d.fe = 1'b0;
    s_d.umc = 1'b0;
    // Fault actions: both kinds flag and log; fatal stops via last sweeps from run, at once from stop
    if (i_fault_event) begin
      s_d.diag = 1'b1;
      s_d.log_p = 1'b1;
      if (i_fault_fatal && run_mode && !s_q.halt_hold) begin
        s_d.stopping = 1'b1;
        s_d.target = RSM_STOP_FAULT;
        s_d.last_cnt = i_last_sweeps;
      end else if (i_fault_fatal && stop_mode) begin
        s_d.mode = RSM_STOP_FAULT;
      end
    end
    // Mode requests; privilege and switch gate them
    if (i_req_valid && i_req_privileged && !s_q.halt_hold && s_q.mode != RSM_STOP_FAULT) begin
      if (i_req_mode == RSM_RUN_OUT_EN || i_req_mode == RSM_RUN_OUT_DIS) begin
        if (!sw_blocks_run && stop_mode) begin
          s_d.mode = rsm_mode_e'(i_req_mode);
          s_d.init_pending = 1'b1;
          s_d.init_p = 1'b1;
        end else if (run_mode) begin
          s_d.mode = rsm_mode_e'(i_req_mode);
        end
      end else if (i_req_mode == RSM_STOP_IO_EN || i_req_mode == RSM_STOP_IO_DIS) begin
        if (run_mode) begin
          s_d.stopping = 1'b1;
          s_d.target = (i_redundant) ? RSM_STOP_IO_DIS : rsm_mode_e'(i_req_mode);
          s_d.last_cnt = i_last_sweeps;
        end else if (stop_mode) begin
          s_d.mode = (i_redundant) ? RSM_STOP_IO_DIS : rsm_mode_e'(i_req_mode);
        end
      end
    end
    // Switch into stop position forces a stop
    if (sw_blocks_run && run_mode && !s_q.stopping) begin
      s_d.stopping = 1'b1;
      s_d.target = stop_target;
      s_d.last_cnt = i_last_sweeps;
    end
    // Switch in a run position selects the output state while running
    if (i_switch_en && run_mode && !s_q.stopping && !i_req_valid) begin
      if (s_q.sw == RSM_SW_RUN_IO) s_d.mode = RSM_RUN_OUT_EN;
      if (s_q.sw == RSM_SW_RUN_OUT) s_d.mode = RSM_RUN_OUT_DIS;
    end
    // Moving the switch into a different run position starts the program; a level would fight tool stops
    if (i_switch_en && stop_mode && s_q.sw != s_q.sw_old && s_q.sw != RSM_SW_STOP) begin
      s_d.mode = (s_q.sw == RSM_SW_RUN_IO) ? RSM_RUN_OUT_EN : RSM_RUN_OUT_DIS;
      s_d.init_pending = 1'b1;
      s_d.init_p = 1'b1;
    end
    // Stop after a number of sweeps, requested by the program
    if (i_stop_after_sweeps_request && run_mode) begin
      s_d.stopping = 1'b1;
      s_d.target = RSM_STOP_IO_DIS; // All I/O to defaults
      s_d.last_cnt = i_stop_after_count;
      s_d.log_p = 1'b1;
    end
    // Count down final sweeps; zero stops at the next sweep end
    if (s_q.stopping && i_sweep_done) begin
      if (s_q.last_cnt == 8'h00) begin
        s_d.stopping = 1'b0;
        s_d.mode = s_q.target;
      end else begin
        s_d.last_cnt = s_q.last_cnt - 8'h01;
      end
    end
    // Init steps complete
    if (i_init_done) s_d.init_pending = 1'b0;
    // Clearing the table recovers from fault stop
    if (i_fault_table_clear) begin
      s_d.diag = i_fault_event; // set wins over clear
      if (s_q.mode == RSM_STOP_FAULT) s_d.mode = RSM_STOP_IO_DIS;
    end
    // Background window cap in stop
    if (stop_mode && !i_sweep_done) begin
      if (s_q.bg_cnt != BGW'(BG_LIMIT_CYC)) s_d.bg_cnt = s_q.bg_cnt + BGW'(1);
      s_d.bg_expired = (s_q.bg_cnt == BGW'(BG_LIMIT_CYC - 1)) || s_q.bg_expired;
    end else begin
      s_d.bg_cnt = '0;
      s_d.bg_expired = 1'b0;
    end
    // Flash copy engine; aborts leave no half image behind
    unique case (s_q.fl)
      RSM_FL_IDLE: begin
        if (i_flash_write_start) begin
          s_d.fl = RSM_FL_WRITE;
          s_d.fw = 1'b1;
        end else if (i_flash_read_start) begin
          s_d.fl = RSM_FL_READ;
        end
      end
      RSM_FL_WRITE: begin
        if (i_flash_abort || i_powerup) begin
          s_d.fe = 1'b1;
          s_d.fl = RSM_FL_IDLE;
        end else if (i_flash_done) s_d.fl = RSM_FL_IDLE;
      end
      RSM_FL_READ: begin
        if (i_flash_abort || i_powerup) begin
          s_d.umc = 1'b1;
          s_d.fl = RSM_FL_IDLE;
        end else if (i_flash_done) s_d.fl = RSM_FL_IDLE;
      end
      default: begin
        s_d.fl = RSM_FL_IDLE;
      end
    endcase
    // Power-up: restore selection and halt exit
    if (i_powerup) begin
      s_d.rl = (i_logic_src == SRC_FLASH_ALWAYS) || (i_logic_src == SRC_FLASH_COND && !i_user_mem_ok);
      s_d.rr = (i_ref_src == SRC_FLASH_ALWAYS) || (i_ref_src == SRC_FLASH_COND && !i_user_mem_ok);
      s_d.roem = s_d.rl || s_d.rr;
      s_d.backplane = 1'b1;
      if (!i_backup_present) begin
        s_d.halt_hold = 1'b0;
        s_d.mode = RSM_STOP_IO_DIS;
        s_d.stopping = 1'b0;
      end
    end
    // Internal faults win over everything
    if (i_wdog_expired || i_ecc_error) begin
      s_d.mode = RSM_STOP_HALT;
      s_d.halt_hold = 1'b1;
      s_d.stopping = 1'b0;
      s_d.backplane = !i_ecc_error;
      s_d.log_p = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{sw_m: 2'b11, sw: 2'b11, sw_old: 2'b11, mode: RSM_STOP_IO_DIS, target: RSM_STOP_IO_DIS,
               last_cnt: `RSM_LAST_SWEEPS_RST, backplane: 1'b1, fl: RSM_FL_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs, all registered; the mode decode is taken from the next state, not the state register
  logic prot_q;
  logic [7:0] out_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prot_q <= 1'b0;
      out_q <= 8'h1d; // Decode of stop with I/O disabled, backplane up
    end else begin
      // Protection only bites in run positions
      prot_q <= i_protect_en && i_switch_en && (s_q.sw != RSM_SW_STOP);
      out_q <= {s_d.mode == RSM_RUN_OUT_EN || s_d.mode == RSM_RUN_OUT_DIS,
                s_d.mode == RSM_RUN_OUT_EN || s_d.mode == RSM_RUN_OUT_DIS || s_d.mode == RSM_STOP_IO_EN,
                s_d.mode == RSM_RUN_OUT_EN || s_d.mode == RSM_STOP_IO_EN,
                s_d.mode != RSM_RUN_OUT_EN && s_d.mode != RSM_STOP_IO_EN,
                s_d.mode == RSM_STOP_IO_EN || s_d.mode == RSM_STOP_IO_DIS,
                s_d.mode != RSM_STOP_FAULT && s_d.mode != RSM_STOP_HALT,
                s_d.mode == RSM_STOP_FAULT,
                s_d.backplane};
    end
  end

  assign o_mode = s_q.mode;
  assign o_exec_logic = out_q[7];
  assign o_scan_inputs = out_q[6];
  assign o_drive_outputs = out_q[5];
  assign o_outputs_default = out_q[4];
  assign o_comms_to_completion = out_q[3];
  assign o_bg_limit_active = out_q[3];
  assign o_client_comms_en = out_q[2];
  assign o_server_frozen = out_q[1];
  assign o_backplane_en = out_q[0];
  assign o_mem_write_protect = prot_q;
  assign o_switch_pos = s_q.sw;
  assign o_switch_cfg_mode = {1'b0, s_q.sw}; // Configured mode mirrors position
  assign o_diag_flag = s_q.diag;
  assign o_fault_log = s_q.log_p;
  assign o_init_pulse = s_q.init_p;
  assign o_restore_logic = s_q.rl;
  assign o_restore_ref = s_q.rr;
  assign o_restore_oem_pw = s_q.roem;
  assign o_flash_write_all = s_q.fw;
  assign o_flash_erase = s_q.fe;
  assign o_user_mem_clear = s_q.umc;
  assign o_bg_expired = s_q.bg_expired;

  // ============================================================
  // Checks
  a_halt_entry: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_wdog_expired || i_ecc_error) |=> (o_mode == RSM_STOP_HALT)) else $error("halt not entered");
  a_ecc_backplane: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_ecc_error |=> ##1 !o_backplane_en) else $error("backplane alive after ecc");
  a_clear_recover: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_fault_table_clear && o_mode == RSM_STOP_FAULT && !i_wdog_expired && !i_ecc_error && !i_powerup)
    |=> o_mode == RSM_STOP_IO_DIS) else $error("fault clear did not recover");
  a_redund_scan: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_redundant |-> o_mode != RSM_STOP_IO_EN || !$past(i_redundant)) else $error("redundant stop scans");
  a_fault_log: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    i_fault_event |=> o_diag_flag && o_fault_log) else $error("fault not logged");
  a_oem_restore: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (o_restore_logic || o_restore_ref) |-> o_restore_oem_pw) else $error("oem not restored");
  a_write_abort: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (s_q.fl == RSM_FL_WRITE && i_flash_abort) |=> o_flash_erase) else $error("no erase on abort");
  a_stop_outputs: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (o_mode == RSM_STOP_IO_DIS) |-> ##1 ($past(s_d.mode) != RSM_STOP_IO_DIS || !o_scan_inputs))
    else $error("scan in stop disabled");
  a_run_outputs: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (o_mode == RSM_RUN_OUT_DIS && !o_exec_logic) |-> $past(s_d.mode) != RSM_RUN_OUT_DIS)
    else $error("run without logic");

endmodule
`default_nettype wire

/* File: design/rsm_params.svh */
/*
  Timing counts and reset values for the run/stop mode controller.
  Assumes a 200 MHz core clock; included by the mode controller module only.
*/
`ifndef RSM_PARAMS_SVH
`define RSM_PARAMS_SVH
// ============================================================
// Timing
`define RSM_CLK_MHZ 200
`define RSM_BG_LIMIT_MS 10
`define RSM_BG_LIMIT_CYC (`RSM_BG_LIMIT_MS * 1000 * `RSM_CLK_MHZ)
// ============================================================
// Reset values
`define RSM_LAST_SWEEPS_RST 8'h00
`define RSM_SWITCH_EN_RST 1'b1
`define RSM_PROTECT_EN_RST 1'b0
`endif

/* File: design/rsm_pkg.sv */
/*
  Types for the run/stop mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsm_pkg;
  // Operating modes, Gray coded along run -> stop -> fault -> halt
  typedef enum logic [2:0] {
    RSM_RUN_OUT_EN  = 3'b000,
    RSM_RUN_OUT_DIS = 3'b001,
    RSM_STOP_IO_EN  = 3'b011,
    RSM_STOP_IO_DIS = 3'b010,
    RSM_STOP_FAULT  = 3'b110,
    RSM_STOP_HALT   = 3'b111
  } rsm_mode_e;
  // Mode switch positions
  typedef enum logic [1:0] {
    RSM_SW_RUN_IO  = 2'b00,
    RSM_SW_RUN_OUT = 2'b01,
    RSM_SW_STOP    = 2'b11
  } rsm_sw_e;
  // Flash copy engine state
  typedef enum logic [1:0] {
    RSM_FL_IDLE  = 2'b00,
    RSM_FL_WRITE = 2'b01,
    RSM_FL_READ  = 2'b11
  } rsm_fl_e;
endpackage

/* File: verif/rsm_sweep_model.sv */
/*
  Sweep engine stand-in that reports the end of each sweep.
  Assumes the controller's core clock and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_sweep_model #(
  parameter int PERIOD = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Sweep end strobe
  output logic o_sweep_done
);
  int cnt;
  // ==========================================================
  // Sweep timer
  // Launched off the falling edge so the strobe is settled at sampling
  always @(negedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
      o_sweep_done <= 1'h0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_sweep_done <= (cnt == PERIOD - 1); // One cycle per sweep
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_run_stop_mode_controller.sv */
/*
  Self-checking bench for the run/stop mode controller.
  Assumes the sweep model beside it; all other inputs driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_run_stop_mode_controller;
  import rsm_pkg::*;
  // ==========================================================
  // Stimulus and observation
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [11:0] pin = 12'h000;
  logic [1:0] sw_pos = 2'h3;
  logic sw_en = 1'h1, prot = 1'h0, scan_cfg = 1'h0, redund = 1'h0, priv = 1'h1;
  logic fatal = 1'h0, backup = 1'h1, mem_ok = 1'h1;
  logic [7:0] last = 8'h00, sas_cnt = 8'h00;
  logic [2:0] req_mode = 3'h2;
  logic [1:0] lsrc = 2'h0, rsrc = 2'h0;
  logic sweep, exec, scan, drv, dflt, comp, bgl, client, frozen, bp, wp, diag, bgx;
  logic [2:0] mode, cfg_mode;
  logic [1:0] pos;
  logic [7:0] pul, seen = 8'h00;
  int n_fail = 0, check_count = 0, cyc = 0, nsw = 0;

  always #2.5 clk = ~clk;

  rsm_sweep_model i_sweep (.i_core_clk(clk), .i_rstn(rstn), .o_sweep_done(sweep));

  // Shortened background limit keeps the run brief
  rsm_mode_ctrl #(.BG_LIMIT_CYC(5)) i_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_switch_pos(sw_pos), .i_switch_en(sw_en),
    .i_protect_en(prot), .i_stop_io_scan_cfg(scan_cfg), .i_redundant(redund),
    .i_last_sweeps(last), .i_logic_src(lsrc), .i_ref_src(rsrc),
    .i_req_valid(pin[0]), .i_req_mode(req_mode), .i_req_privileged(priv),
    .i_stop_after_sweeps_request(pin[1]), .i_stop_after_count(sas_cnt),
    .i_sweep_done(sweep), .i_fault_event(pin[2]), .i_fault_fatal(fatal),
    .i_fault_table_clear(pin[3]), .i_wdog_expired(pin[4]), .i_ecc_error(pin[5]),
    .i_powerup(pin[6]), .i_backup_present(backup), .i_user_mem_ok(mem_ok),
    .i_flash_write_start(pin[7]), .i_flash_read_start(pin[8]), .i_flash_done(pin[9]),
    .i_flash_abort(pin[10]), .i_init_done(pin[11]),
    .o_mode(mode), .o_exec_logic(exec), .o_scan_inputs(scan), .o_drive_outputs(drv),
    .o_outputs_default(dflt), .o_comms_to_completion(comp), .o_bg_limit_active(bgl),
    .o_client_comms_en(client), .o_server_frozen(frozen), .o_backplane_en(bp),
    .o_mem_write_protect(wp), .o_switch_pos(pos), .o_switch_cfg_mode(cfg_mode),
    .o_diag_flag(diag), .o_fault_log(pul[7]), .o_init_pulse(pul[6]),
    .o_restore_logic(pul[5]), .o_restore_ref(pul[4]), .o_restore_oem_pw(pul[3]),
    .o_flash_write_all(pul[2]), .o_flash_erase(pul[1]), .o_user_mem_clear(pul[0]),
    .o_bg_expired(bgx)
  );

  // Sticky record of one-cycle strobes and a sweep tally
  always @(posedge clk) begin
    seen <= seen | pul;
    nsw <= nsw + int'(sweep);
  end

  // ==========================================================
  // Helpers
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic fire(input int b);
    @(negedge clk);
    pin[b] = 1'h1;
    @(negedge clk);
    pin[b] = 1'h0;
  endtask
  task automatic ask(input logic [2:0] m);
    req_mode = m;
    fire(0);
  endtask
  // Bounded wait; a mode change may wait for the end of a sweep
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clk);
    chk(mode, m, "mode");
  endtask
  task automatic go(input logic [2:0] m);
    ask(m);
    wait_mode(m, 40);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk(mode, RSM_STOP_IO_DIS, "reset mode");
    chk({exec, scan, drv, bp, wp}, 8'h02, "reset lv");
  endtask
  task automatic t_switch;
    ask(RSM_RUN_OUT_EN);
    idle(2);
    chk(mode, RSM_STOP_IO_DIS, "stop pos");
    sw_en = 1'h0;
    priv = 1'h0;
    ask(RSM_RUN_OUT_EN);
    idle(2);
    chk(mode, RSM_STOP_IO_DIS, "unpriv");
    priv = 1'h1;
    sw_en = 1'h1;
    prot = 1'h1;
    sw_pos = 2'h1;
    wait_mode(RSM_RUN_OUT_DIS, 12);
    chk({drv, dflt, exec, scan, wp}, 8'h0f, "run dis");
    chk({pos, cfg_mode}, 8'h09, "sw read");
    sw_pos = 2'h3;
    idle(4);
    go(RSM_STOP_IO_DIS);
    chk(wp, 1'h0, "stop wr");
    sw_en = 1'h0;
    prot = 1'h0;
  endtask
  task automatic t_run;
    seen = 8'h00;
    go(RSM_RUN_OUT_EN);
    chk({exec, scan, drv, dflt}, 8'h0e, "run en");
    idle(1);
    chk(seen[6], 1'h1, "init");
  endtask
  task automatic t_last;
    int n0;
    last = 8'h02;
    scan_cfg = 1'h1;
    ask(RSM_STOP_IO_EN);
    n0 = nsw;
    chk(mode, RSM_RUN_OUT_EN, "last run");
    wait_mode(RSM_STOP_IO_EN, 60);
    chk(8'(nsw - n0 >= 2 && nsw - n0 <= 4), 8'h01, "sweeps");
    chk({exec, scan, comp, bgl}, 8'h07, "stop en");
    last = 8'h00;
  endtask
  task automatic t_redund;
    go(RSM_STOP_IO_DIS);
    chk({scan, exec, comp}, 8'h01, "stop dis");
    redund = 1'h1;
    ask(RSM_STOP_IO_EN);
    idle(4);
    chk(scan, 1'h0, "redund");
    for (int i = 0; i < 10 && bgx !== 1'h1; i++) @(negedge clk);
    chk(bgx, 1'h1, "bg cap");
    redund = 1'h0;
    go(RSM_STOP_IO_DIS);
  endtask
  task automatic t_fault;
    seen = 8'h00;
    fire(2);
    idle(2);
    chk({mode, diag, seen[7]}, 8'h0b, "diag");
    go(RSM_RUN_OUT_EN);
    fatal = 1'h1;
    fire(2);
    wait_mode(RSM_STOP_FAULT, 40);
    chk({exec, scan, client, frozen}, 8'h01, "fstop");
    fatal = 1'h0;
    ask(RSM_RUN_OUT_EN);
    idle(2);
    chk(mode, RSM_STOP_FAULT, "fs req");
    fire(3);
    wait_mode(RSM_STOP_IO_DIS, 4);
  endtask
  task automatic t_sas;
    go(RSM_RUN_OUT_EN);
    seen = 8'h00;
    sas_cnt = 8'h01;
    fire(1);
    for (int i = 0; i < 60 && mode[1] !== 1'h1; i++) @(negedge clk);
    idle(1);
    chk({mode[1], dflt, seen[7]}, 8'h07, "sas");
    go(RSM_STOP_IO_DIS);
  endtask
  task automatic t_halt;
    fire(4);
    wait_mode(RSM_STOP_HALT, 4);
    chk({exec, scan, bp}, 8'h01, "wdog");
    ask(RSM_STOP_IO_DIS);
    fire(5);
    idle(2);
    chk({mode, bp}, 8'h0e, "ecc");
    fire(6);
    idle(2);
    chk({mode, bp}, 8'h0f, "bk pwr");
    backup = 1'h0;
    fire(6);
    wait_mode(RSM_STOP_IO_DIS, 4);
    backup = 1'h1;
  endtask
  task automatic t_flash;
    seen = 8'h00;
    fire(7);
    fire(9);
    idle(2);
    chk(seen[2:0], 8'h04, "wr ok");
    seen = 8'h00;
    fire(7);
    fire(10);
    idle(2);
    chk(seen[1:0], 8'h02, "wr abort");
    seen = 8'h00;
    fire(8);
    fire(10);
    idle(2);
    chk(seen[1:0], 8'h01, "rd abort");
  endtask
  // Rows: logic src, ref src, memory kept, then logic/ref/OEM restores
  task automatic t_power;
    logic [7:0] tab [6] = '{8'h6b, 8'h45, 8'h57, 8'h08, 8'h8d, 8'h13};
    foreach (tab[i]) begin
      {lsrc, rsrc, mem_ok} = tab[i][7:3];
      seen = 8'h00;
      fire(6);
      idle(2);
      chk(seen[5:3], tab[i][2:0], "restore");
    end
  endtask

  // ==========================================================
  // Sequence and hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    idle(5);
    rstn = 1'h1;
    idle(2);
    t_reset;
    t_switch;
    t_run;
    t_last;
    t_redund;
    t_fault;
    t_sas;
    t_halt;
    t_flash;
    t_power;
    print_verdict;
  end
endmodule
`default_nettype wire
